/* File: hw/ctsp_pkg.sv */
`include "ctsp_regs.svh"
package ctsp_pkg;
  typedef enum logic [2:0] {
    CTSP_H_IDLE = 3'h0,
    CTSP_H_FILL = 3'h1,
    CTSP_H_WAIT = 3'h2,
    CTSP_H_POST = 3'h3,
    CTSP_H_DONE = 3'h4
  } ctsp_hist_e;
  typedef logic [4:0][15:0] ctsp_half_t;
  typedef struct packed {
    ctsp_half_t [1:0] half_sample_bus;
    logic [1:0]       strobe;
  } ctsp_fe_out_s;
  typedef struct packed {
    logic [15:0] first_config_word, dig_en, thresh;
    logic        arm;
    logic [15:0] mask_a, mask_b, rdata, hi;
  } ctsp_regs_s;
  typedef struct packed {
    logic run, in_v;
    ctsp_half_t [1:0] in_fe;
    logic [5:0][15:0] in_loc, loc;
    logic [1:0][17:0] a0, a1;
    logic [1:0][18:0] b;
    logic [17:0] sa, sb;
    logic [19:0] fe_s;
    logic [18:0] loc_s;
    logic [19:0] fin;
    logic [`CTSP_DLY_LEN-1:0][19:0] dly;
    logic [`CTSP_ADD_LAT_CYC-1:0]   vp;
    logic odd, fv, trig, done, mism;
    logic [19:0] even;
    logic [63:0] fiber;
    ctsp_hist_e hst;
    logic [8:0] hw, hcnt, hr;
    logic [15:0] tcnt;
    logic [1:0][9:0] rptr, rgray;
  } ctsp_dp_s;
  typedef struct packed {
    logic sync_m, sync_s, rst_link;
    logic [1:0] ok_m, ok_s;
    logic [1:0][9:0] wg_m, wg_s;
    ctsp_regs_s regs;
    ctsp_dp_s   dp;
  } ctsp_core_s;
  typedef struct packed {
    logic rst_m, rst_s, ce_m, ce_s, phase;
    logic [1:0][9:0] rg_m, rg_s, wptr, wgray;
    ctsp_half_t [1:0] low_half, half_sample_bus;
    logic [1:0] strobe, lag_ok;
    logic [1:0][3:0] lag;
  } ctsp_link_s;
endpackage

/* File: hw/ctsp_regs.svh */
`ifndef CTSP_REGS_SVH
`define CTSP_REGS_SVH
// Register indices on the 16-bit register port
`define CTSP_REG_FIRST_CONFIG_WORD   5'h00
`define CTSP_REG_DIG_EN    5'h01
`define CTSP_REG_THRESH    5'h02
`define CTSP_REG_ARM       5'h03
`define CTSP_REG_STATUS    5'h04
`define CTSP_REG_HIST_LO   5'h06
`define CTSP_REG_HIST_HI   5'h07
`define CTSP_REG_MASK_A    5'h08
`define CTSP_REG_MASK_B    5'h09
// Field positions
`define CTSP_CFG_TEST_BIT  0
`define CTSP_CFG_ALIGN_BIT 3
`define CTSP_ARM_BIT       0
// Reset values
`define CTSP_FIRST_CONFIG_WORD_RST   16'h0000
`define CTSP_DIG_EN_RST    16'hffff
`define CTSP_THRESH_RST    16'hffff
// Alignment markers
`define CTSP_MARKER_A      16'h0002
`define CTSP_MARKER_B      16'h0001
`define CTSP_MARKER_REPEAT 3
// Timing
`define CTSP_CLK_NS        10
`define CTSP_LINK_NS       4
`define CTSP_SYNC_MIN_NS   500
`define CTSP_EMPTY_LAG_NS  32
`define CTSP_EMPTY_LAG_CYC (`CTSP_EMPTY_LAG_NS / `CTSP_LINK_NS)
`define CTSP_ADD_LAT_NS    44
`define CTSP_ADD_LAT_CYC   (`CTSP_ADD_LAT_NS / `CTSP_LINK_NS)
`define CTSP_DLY_LEN       (`CTSP_ADD_LAT_CYC - 4)
`define CTSP_TOTAL_LAT_CYC 27
// History buffer
`define CTSP_HIST_PRE      256
`define CTSP_HIST_POST     255
`endif

/* File: hw/ctsp_trigger_sum.sv */
`timescale 1ns/100ps
`include "ctsp_regs.svh"
// Functional notes
// - Sync high holds the datapath and link logic in reset; registers keep their settings
// - Marker alignment through FIFOs when config bit 3
// - Front end sends upper half before lower half
// - Registered halves with strobe; strobe drops on sync
// - Link clock forwarded out and captures link data
// - Front ends with all five digitizers disabled not awaited; disabled digitizers summed as zero
// - Strobe writes 80-bit words into 512-deep FIFO
// - FIFO empty clears 8 clocks after strobe rise
// - Both front-end FIFOs read together on marker 2
// - Sum in four pipelined adder stages
// - Adder latency exactly 11 clocks
// - Two sums packed per 64-bit fiber word
// - Trigger high while sum exceeds threshold
// - History holds 512, stops 255 after trigger
// - Trigger on hit bit under mask registers
// - Store 256 hit patterns before watching for a hit
// - Done flag on stop, cleared by arm write
// - Test mismatch sets latch, cleared by sync
// - First sum 27 clocks after slowest data
module ctsp_trigger_sum (
  // Clocks, reset, enable
  input  wire logic                   i_clk,
  input  wire logic                   i_reset,
  input  wire logic                   i_ce,
  input  wire logic                   i_link_clk,
  // Crate sync pin
  input  wire logic                   i_sync,
  // Digitizer samples on link clock, held two link cycles
  input  wire logic [1:0][4:0][31:0]  i_fe_sample,
  // Local digitizer words and hit pattern on i_clk
  input  wire logic [5:0][15:0]       i_loc_word,
  input  wire logic [31:0]            i_hit_pattern,
  // Register port
  input  wire logic                   i_reg_wr,
  input  wire logic                   i_reg_rd,
  input  wire logic [4:0]             i_reg_addr,
  input  wire logic [15:0]            i_reg_wdata,
  output logic [15:0]                 o_reg_rdata,
  // Front-end link
  output ctsp_pkg::ctsp_fe_out_s      o_fe_link,
  output logic                        o_forwarded_capture_clock,
  // Results
  output logic [19:0]                 o_final_sum,
  output logic                        o_sum_valid,
  output logic [63:0]                 o_fiber_word,
  output logic                        o_fiber_valid,
  output logic                        o_trigger,
  output logic                        o_capture_done_flag,
  output logic                        o_sum_mismatch_latch
);
  localparam logic [3:0]  LAG_CYC  = 4'(`CTSP_EMPTY_LAG_CYC);
  localparam logic [8:0]  PRE_LAST = 9'(`CTSP_HIST_PRE - 1);
  localparam logic [8:0]  PST_LAST = 9'(`CTSP_HIST_POST - 1);

  ctsp_pkg::ctsp_core_s   r;
  ctsp_pkg::ctsp_core_s   n;
  ctsp_pkg::ctsp_link_s   l;
  ctsp_pkg::ctsp_link_s   nl;
  ctsp_pkg::ctsp_half_t   fifo_mem [2][512];
  logic [31:0]            hist_mem [512];
  ctsp_pkg::ctsp_half_t [1:0] head;
  ctsp_pkg::ctsp_half_t [1:0] fm;
  logic [1:0][9:0]        wb;
  logic [1:0][9:0]        rb;
  logic [1:0]             wr_en;
  logic [1:0]             full;
  logic [1:0]             empty;
  logic [1:0]             need;
  logic [1:0]             ready;
  logic [1:0]             marker;
  logic [1:0]             rd_en;
  logic                   go;
  logic                   store;
  logic                   hit;
  logic                   done_set;
  logic [4:0]             nen;
  logic [19:0]            expect_s;
  logic [31:0]            hist_rd;
  logic [5:0][15:0]       lm;

  function automatic logic [9:0] g2b(input logic [9:0] g);
    logic [9:0] b;
    b[9] = g[9];
    for (int i = 8; i >= 0; i--)
      b[i] = b[i + 1] ^ g[i];
    return b;
  endfunction

  function automatic logic [9:0] b2g(input logic [9:0] b);
    return (b >> 1) ^ b;
  endfunction

  // Link domain: front-end halves, strobe and FIFO write side
  always_comb
  begin
    nl = l;
    for (int f = 0; f < 2; f++)
    begin
      rb[f]    = g2b(l.rg_s[f]);
      full[f]  = (l.wptr[f][9] != rb[f][9]) && (l.wptr[f][8:0] == rb[f][8:0]);
      wr_en[f] = l.strobe[f] && !full[f];
    end
    if (l.ce_s)
    begin
      nl.phase = ~l.phase;
      for (int f = 0; f < 2; f++)
      begin
        for (int k = 0; k < 5; k++)
        begin
          if (!l.phase)
          begin
            nl.half_sample_bus[f][k] = i_fe_sample[f][k][31:16];
            nl.low_half[f][k]        = i_fe_sample[f][k][15:0];
          end
          else
            nl.half_sample_bus[f][k] = l.low_half[f][k];
        end
        // Strobe rises with the first marker-2 word on the bus
        if (!l.strobe[f] && ((l.phase ? l.low_half[f][0] : i_fe_sample[f][0][31:16])
            == `CTSP_MARKER_A))
          nl.strobe[f] = 1'b1;
        if (wr_en[f])
        begin
          nl.wptr[f]  = l.wptr[f] + 10'h001;
          nl.wgray[f] = b2g(nl.wptr[f]);
        end
        if (l.strobe[f] && l.lag[f] != LAG_CYC)
          nl.lag[f] = l.lag[f] + 4'h1;
        nl.lag_ok[f] = (nl.lag[f] == LAG_CYC);
      end
    end
    if (l.rst_s)
      nl = '0;
    nl.rst_m = r.rst_link;
    nl.rst_s = l.rst_m;
    nl.ce_m  = i_ce;
    nl.ce_s  = l.ce_m;
    nl.rg_m  = r.dp.rgray;
    nl.rg_s  = l.rg_m;
  end

  // Link state rests on the reset carried over from the core domain
  always_ff @(posedge i_link_clk)
  begin
    l <= nl;
  end

  always_ff @(posedge i_link_clk)
  begin
    for (int f = 0; f < 2; f++)
      if (wr_en[f] && l.ce_s && !l.rst_s)
        fifo_mem[f][l.wptr[f][8:0]] <= l.half_sample_bus[f];
  end

  // First-word-fall-through heads
  for (genvar f = 0; f < 2; f++)
  begin : g_head
    assign head[f] = fifo_mem[f][r.dp.rptr[f][8:0]];
  end

  assign hist_rd = hist_mem[r.dp.hr];

  // Core domain
  always_comb
  begin
    n        = r;
    go       = 1'b0;
    rd_en    = '0;
    fm       = '0;
    lm       = '0;
    hit      = |({r.regs.mask_b, r.regs.mask_a} & i_hit_pattern);
    store    = r.dp.vp[`CTSP_ADD_LAT_CYC-1] && (r.dp.hst != ctsp_pkg::CTSP_H_DONE);
    done_set = 1'b0;
    nen      = 5'($countones(r.regs.dig_en));
    expect_s = 20'(21'(r.dp.tcnt) * 21'(nen));
    for (int f = 0; f < 2; f++)
    begin
      wb[f]     = g2b(r.wg_s[f]);
      empty[f]  = !r.ok_s[f] || (wb[f] == r.dp.rptr[f]);
      need[f]   = |r.regs.dig_en[f*5 +: 5];
      ready[f]  = !need[f] || !empty[f];
      marker[f] = !need[f] || (!empty[f] && head[f][0] == `CTSP_MARKER_A);
    end
    if (i_ce)
    begin
      n.sync_m   = i_sync;
      n.sync_s   = r.sync_m;
      n.rst_link = r.sync_s;
      n.ok_m     = l.lag_ok;
      n.ok_s     = r.ok_m;
      n.wg_m     = l.wgray;
      n.wg_s     = r.wg_m;
      // Alignment: wait once for marker 2 on all needed heads
      go = (&ready) && (r.dp.run || !r.regs.first_config_word[`CTSP_CFG_ALIGN_BIT] || (&marker));
      if (go)
        rd_en = need;
      n.dp.in_v = go;
      n.dp.run  = r.dp.run | go;
      for (int f = 0; f < 2; f++)
      begin
        n.dp.in_fe[f] = rd_en[f] ? head[f] : '0;
        if (rd_en[f])
        begin
          n.dp.rptr[f]  = r.dp.rptr[f] + 10'h001;
          n.dp.rgray[f] = b2g(n.dp.rptr[f]);
        end
      end
      n.dp.in_loc = go ? i_loc_word : '0;
      // Stage 1: group fields, disabled digitizers read as zero
      for (int f = 0; f < 2; f++)
        for (int k = 0; k < 5; k++)
          fm[f][k] = r.regs.dig_en[f*5 + k] ? r.dp.in_fe[f][k] : 16'h0000;
      for (int k = 0; k < 6; k++)
        lm[k] = r.regs.dig_en[10 + k] ? r.dp.in_loc[k] : 16'h0000;
      for (int f = 0; f < 2; f++)
      begin
        n.dp.a0[f] = 18'(fm[f][0]) + 18'(fm[f][1]) + 18'(fm[f][2]);
        n.dp.a1[f] = 18'(fm[f][3]) + 18'(fm[f][4]);
        // Stage 2: front-end partial sums
        n.dp.b[f]  = 19'(r.dp.a0[f]) + 19'(r.dp.a1[f]);
      end
      n.dp.loc  = lm;
      n.dp.sa   = 18'(r.dp.loc[0]) + 18'(r.dp.loc[1]) + 18'(r.dp.loc[2]);
      n.dp.sb   = 18'(r.dp.loc[3]) + 18'(r.dp.loc[4]) + 18'(r.dp.loc[5]);
      // Stage 3 and 4
      n.dp.fe_s  = 20'(r.dp.b[0]) + 20'(r.dp.b[1]);
      n.dp.loc_s = 19'(r.dp.sa) + 19'(r.dp.sb);
      n.dp.fin   = r.dp.fe_s + 20'(r.dp.loc_s);
      // Balancing delay so latency is fixed; total with link path is 27
      n.dp.dly = {r.dp.dly[`CTSP_DLY_LEN-2:0], r.dp.fin};
      n.dp.vp  = {r.dp.vp[`CTSP_ADD_LAT_CYC-2:0], r.dp.in_v};
      // Fiber packing
      n.dp.fv = 1'b0;
      if (r.dp.vp[`CTSP_ADD_LAT_CYC-1])
      begin
        n.dp.odd = ~r.dp.odd;
        if (!r.dp.odd)
          n.dp.even = r.dp.dly[`CTSP_DLY_LEN-1];
        else
        begin
          n.dp.fiber = {24'h000000, r.dp.even, r.dp.dly[`CTSP_DLY_LEN-1]};
          n.dp.fv    = 1'b1;
        end
      end
      n.dp.trig = r.dp.dly[`CTSP_DLY_LEN-1] > {4'h0, r.regs.thresh};
      // Self-test compare against count times enabled digitizers
      if (r.dp.vp[`CTSP_ADD_LAT_CYC-1] && r.regs.first_config_word[`CTSP_CFG_TEST_BIT])
      begin
        n.dp.tcnt = r.dp.tcnt + 16'h0001;
        if (r.dp.dly[`CTSP_DLY_LEN-1] != expect_s)
          n.dp.mism = 1'b1;
      end
      // History buffer records until done
      if (store)
      begin
        n.dp.hw = r.dp.hw + 9'h001;
        case (r.dp.hst)
          ctsp_pkg::CTSP_H_FILL:
            if (r.dp.hcnt == PRE_LAST)
              n.dp.hst = ctsp_pkg::CTSP_H_WAIT;
            else
              n.dp.hcnt = r.dp.hcnt + 9'h001;
          ctsp_pkg::CTSP_H_WAIT:
            if (hit)
            begin
              n.dp.hst  = ctsp_pkg::CTSP_H_POST;
              n.dp.hcnt = '0;
            end
          ctsp_pkg::CTSP_H_POST:
            if (r.dp.hcnt == PST_LAST)
            begin
              n.dp.hst = ctsp_pkg::CTSP_H_DONE;
              n.dp.done = 1'b1;
              done_set  = 1'b1;
              n.dp.hr   = r.dp.hw + 9'h001;
            end
            else
              n.dp.hcnt = r.dp.hcnt + 9'h001;
          default: ;
        endcase
      end
      // Register writes
      if (i_reg_wr)
      begin
        case (i_reg_addr)
          `CTSP_REG_FIRST_CONFIG_WORD: n.regs.first_config_word = i_reg_wdata;
          `CTSP_REG_DIG_EN:  n.regs.dig_en  = i_reg_wdata;
          `CTSP_REG_THRESH:  n.regs.thresh  = i_reg_wdata;
          `CTSP_REG_MASK_A:  n.regs.mask_a  = i_reg_wdata;
          `CTSP_REG_MASK_B:  n.regs.mask_b  = i_reg_wdata;
          `CTSP_REG_ARM:
          begin
            n.regs.arm = i_reg_wdata[`CTSP_ARM_BIT];
            n.dp.hr    = r.dp.hw;
            if (!done_set)
              n.dp.done = 1'b0;
            // Capture starts on the return to zero
            if (r.regs.arm && !i_reg_wdata[`CTSP_ARM_BIT])
            begin
              n.dp.hst  = ctsp_pkg::CTSP_H_FILL;
              n.dp.hcnt = '0;
            end
          end
          default: ;
        endcase
      end
      // Register reads; history read advances on the high half
      if (i_reg_rd)
      begin
        case (i_reg_addr)
          `CTSP_REG_FIRST_CONFIG_WORD: n.regs.rdata = r.regs.first_config_word;
          `CTSP_REG_DIG_EN:  n.regs.rdata = r.regs.dig_en;
          `CTSP_REG_THRESH:  n.regs.rdata = r.regs.thresh;
          `CTSP_REG_ARM:     n.regs.rdata = {15'h0000, r.regs.arm};
          `CTSP_REG_STATUS:
            n.regs.rdata = {10'h000, r.dp.hst, r.dp.run, r.dp.mism, r.dp.done};
          `CTSP_REG_HIST_LO:
          begin
            n.regs.rdata = hist_rd[15:0];
            n.regs.hi    = hist_rd[31:16];
          end
          `CTSP_REG_HIST_HI:
          begin
            n.regs.rdata = r.regs.hi;
            n.dp.hr      = r.dp.hr + 9'h001;
          end
          `CTSP_REG_MASK_A:  n.regs.rdata = r.regs.mask_a;
          `CTSP_REG_MASK_B:  n.regs.rdata = r.regs.mask_b;
          default:           n.regs.rdata = 16'h0000;
        endcase
      end
      // Sync clears the whole datapath but keeps software settings
      if (r.sync_s)
        n.dp = '0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      r                <= '0;
      r.rst_link       <= 1'b1;
      r.regs.first_config_word   <= `CTSP_FIRST_CONFIG_WORD_RST;
      r.regs.dig_en    <= `CTSP_DIG_EN_RST;
      r.regs.thresh    <= `CTSP_THRESH_RST;
    end
    else
      r <= n;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_ce && store && !r.sync_s)
      hist_mem[r.dp.hw] <= i_hit_pattern;
  end

  assign o_reg_rdata               = r.regs.rdata;
  assign o_fe_link                 = {l.half_sample_bus, l.strobe};
  assign o_forwarded_capture_clock = i_link_clk;
  assign o_final_sum               = r.dp.dly[`CTSP_DLY_LEN-1];
  assign o_sum_valid               = r.dp.vp[`CTSP_ADD_LAT_CYC-1];
  assign o_fiber_word              = r.dp.fiber;
  assign o_fiber_valid             = r.dp.fv;
  assign o_trigger                 = r.dp.trig;
  assign o_capture_done_flag       = r.dp.done;
  assign o_sum_mismatch_latch      = r.dp.mism;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  sequence s_ce_run;
    i_ce [*8] ##1 i_ce ##1 i_ce;
  endsequence

  a_sync_clears: assert property ((r.sync_s && i_ce) |=> !r.dp.run && r.dp.vp == '0 && !r.dp.mism)
    else $error("sync did not clear datapath");
  a_add_latency: assert property (@(posedge i_clk) disable iff (i_reset || r.sync_s)
    (r.dp.in_v && i_ce) ##1 s_ce_run |=> r.dp.vp[10]) else $error("sum not valid 11 clocks after input");
  a_marker_wait: assert property ((go && !r.dp.run && r.regs.first_config_word[3] && need[0])
    |-> head[0][0] == 16'h0002 && !empty[0])
    else $error("front end read before marker");
  a_pair_read: assert property ((go && need == 2'b11) |-> rd_en == 2'b11)
    else $error("front-end FIFOs not read together");
  a_empty_lag: assert property (!r.ok_s[0] |-> empty[0] && rd_en[0] == 1'b0)
    else $error("FIFO read before empty lag");
  a_trig_thresh: assert property ((i_ce && !r.sync_s) |=>
    r.dp.trig == ($past(r.dp.dly[6]) > {4'h0, $past(r.regs.thresh)}))
    else $error("trigger disagrees with threshold");
  a_fiber_pack: assert property ((r.dp.fv && $past(i_ce)) |->
    r.dp.fiber[63:40] == 24'h0 && r.dp.fiber[19:0] == $past(r.dp.dly[6]))
    else $error("fiber word packed wrong");
  a_fill_to_wait: assert property ((i_ce && !r.sync_s && store && !i_reg_wr
    && r.dp.hst == ctsp_pkg::CTSP_H_FILL && r.dp.hcnt == 9'd255)
    |=> r.dp.hst == ctsp_pkg::CTSP_H_WAIT)
    else $error("history did not wait after 256 stores");
  a_done_raise: assert property ((i_ce && !r.sync_s && store && r.dp.hcnt == 9'd254
    && r.dp.hst == ctsp_pkg::CTSP_H_POST) |=> r.dp.done)
    else $error("done flag not raised at stop");
  a_done_frozen: assert property ((r.dp.hst == ctsp_pkg::CTSP_H_DONE && !r.sync_s)
    |=> $stable(r.dp.hw))
    else $error("history kept storing after stop");
  a_mism_sticky: assert property ((r.dp.mism && !r.sync_s) |=> r.dp.mism)
    else $error("mismatch latch cleared without sync");
  a_strobe_drop: assert property (@(posedge i_link_clk) disable iff (i_reset)
    l.rst_s |=> l.strobe == 2'b00)
    else $error("strobe high during sync");
  a_upper_first: assert property (@(posedge i_link_clk) disable iff (i_reset)
    (l.ce_s && !l.rst_s && !l.phase) |=>
    l.half_sample_bus[0][0] == $past(i_fe_sample[0][0][31:16]))
    else $error("upper half not sent first");
endmodule

/* File: tb/ctsp_digitizer_model.sv */
`timescale 1ns/100ps
`include "ctsp_regs.svh"
module ctsp_digitizer_model (
  // Link clock and crate sync
  input  wire logic                  i_link_clk,
  input  wire logic                  i_sync,
  // High: counting sequence, low: fixed pattern
  input  wire logic                  i_count_mode,
  // Samples toward both front ends
  output logic [1:0][4:0][31:0]      o_fe_sample
);
  logic        sync_q;
  logic        ph_q;
  logic [4:0]  gap_q;
  logic [15:0] n_q;
  logic [31:0] word_q;

  initial
  begin
    sync_q = 1'b1;
    ph_q   = 1'b0;
    gap_q  = 5'h00;
    n_q    = 16'h0000;
    word_q = 32'h5555aaaa;
  end

  // Same word to every digitizer, so a disabled one would show in the sum
  assign o_fe_sample = {10{word_q}};

  always @(posedge i_link_clk)
  begin
    sync_q <= i_sync;
    if (sync_q)
    begin
      // Nothing sent during sync; lines keep toggling, never a marker
      ph_q   <= 1'b0;
      gap_q  <= 5'h00;
      n_q    <= 16'h0000;
      word_q <= ~word_q;
    end
    else
    begin
      ph_q <= ~ph_q;
      // Each sample held two link cycles
      if (!ph_q)
      begin
        if (gap_q != 5'h0b)
          gap_q <= gap_q + 5'h01;
        if (gap_q < 5'h08)
          word_q <= ~word_q;
        else if (gap_q < 5'h0b)
          word_q <= {`CTSP_MARKER_A, `CTSP_MARKER_B};
        else
        begin
          word_q <= i_count_mode ? {n_q, n_q + 16'h0001} : 32'h00030003;
          n_q    <= n_q + 16'h0002;
        end
      end
    end
  end
endmodule

/* File: tb/tb.sv */
`timescale 1ns/100ps
`include "ctsp_regs.svh"
module tb;
  localparam int NEN = 9;
  localparam logic [15:0] THR = 16'h005a;
  logic                  i_clk, i_reset, i_ce, i_link_clk, i_sync, count_mode;
  logic [1:0][4:0][31:0] fe_sample;
  logic [5:0][15:0]      i_loc_word;
  logic [31:0]           i_hit_pattern;
  logic                  i_reg_wr, i_reg_rd;
  logic [4:0]            i_reg_addr;
  logic [15:0]           i_reg_wdata, o_reg_rdata, rd;
  ctsp_pkg::ctsp_fe_out_s o_fe_link;
  logic                  o_forwarded_capture_clock, o_sum_valid, o_fiber_valid;
  logic                  o_trigger, o_capture_done_flag, o_sum_mismatch_latch;
  logic [19:0]           o_final_sum;
  logic [63:0]           o_fiber_word;
  int                    err_count, checked, n_sum, n_fib, base;
  logic                  sum_chk, trig_chk, t_exp, stb_prev, up_next;
  logic [4:0]            ra [5] = '{`CTSP_REG_FIRST_CONFIG_WORD, `CTSP_REG_DIG_EN, `CTSP_REG_THRESH,
                                    `CTSP_REG_MASK_A, `CTSP_REG_MASK_B};
  logic [15:0]           rv [5] = '{`CTSP_FIRST_CONFIG_WORD_RST, `CTSP_DIG_EN_RST, `CTSP_THRESH_RST,
                                    16'h0000, 16'h0000};

  ctsp_trigger_sum i_ctsp_trigger_sum (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
    .i_link_clk(i_link_clk), .i_sync(i_sync), .i_fe_sample(fe_sample),
    .i_loc_word(i_loc_word), .i_hit_pattern(i_hit_pattern), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_fe_link(o_fe_link),
    .o_forwarded_capture_clock(o_forwarded_capture_clock), .o_final_sum(o_final_sum),
    .o_sum_valid(o_sum_valid), .o_fiber_word(o_fiber_word), .o_fiber_valid(o_fiber_valid),
    .o_trigger(o_trigger), .o_capture_done_flag(o_capture_done_flag),
    .o_sum_mismatch_latch(o_sum_mismatch_latch));
  ctsp_digitizer_model i_ctsp_digitizer_model (.i_link_clk(i_link_clk), .i_sync(i_sync),
    .i_count_mode(count_mode), .o_fe_sample(fe_sample));

  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial
  begin
    i_link_clk = 1'b0;
    #3;
    forever #40 i_link_clk = ~i_link_clk;
  end

  task automatic check(input string nm, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge i_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    @(posedge i_clk);
    #1;
    d = o_reg_rdata;
  endtask
  task automatic wait_sums(input int t);
    for (int k = 0; k < 20000 && n_sum < t; k++)
      @(posedge i_clk);
    if (n_sum < t)
    begin
      $display("CHECK FAILED sum_count expected %0d seen %0d", t, n_sum);
      err_count++;
      test_done();
    end
  endtask
  task automatic sync_pulse();
    @(posedge i_clk);
    i_sync <= 1'b1;
    repeat (30) @(posedge i_clk);
    #1;
    check("fe_strobe", 64'h0, 64'(o_fe_link.strobe));
    check("mismatch", 64'h0, 64'(o_sum_mismatch_latch));
    repeat (30) @(posedge i_clk);
    n_sum = 0;
    n_fib = 0;
    i_sync <= 1'b0;
  endtask

  function automatic logic [19:0] exp_sum(input int i);
    if (i < 6)
      exp_sum = (i % 2 == 0) ? 20'(2 * NEN) : 20'(NEN);
    else
      exp_sum = 20'(NEN * (i - 6));
  endfunction

  // Sum, trigger and fiber checks against the counting stream
  always @(posedge i_clk)
  begin
    if (trig_chk)
      check("trigger", 64'(t_exp), 64'(o_trigger));
    trig_chk = 1'b0;
    if (o_fiber_valid === 1'b1)
    begin
      if (sum_chk)
        check("fiber", {24'h0, exp_sum(2 * n_fib), exp_sum(2 * n_fib + 1)}, o_fiber_word);
      n_fib++;
    end
    if (o_sum_valid === 1'b1)
    begin
      if (sum_chk)
      begin
        check("final_sum", 64'(exp_sum(n_sum)), 64'(o_final_sum));
        t_exp = exp_sum(n_sum) > 20'(THR);
        trig_chk = 1'b1;
      end
      n_sum++;
    end
  end

  // Marker half first, then the lower half
  always @(posedge i_link_clk)
  begin
    if (up_next)
      check("lower_half", 64'h1, 64'(o_fe_link.half_sample_bus[0][0]));
    up_next = 1'b0;
    if (o_fe_link.strobe[0] === 1'b1 && stb_prev !== 1'b1)
    begin
      check("upper_half", 64'h2, 64'(o_fe_link.half_sample_bus[0][0]));
      up_next = 1'b1;
    end
    stb_prev = o_fe_link.strobe[0];
  end

  initial
  begin
    {err_count, checked, n_sum, n_fib} = '0;
    {sum_chk, trig_chk, up_next} = '0;
    {i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = '0;
    i_reset = 1'b1;
    i_sync = 1'b1;
    i_ce = 1'b1;
    count_mode = 1'b1;
    i_loc_word = {6{16'h0123}};
    i_hit_pattern = 32'h00018000;
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      reg_rd(ra[i], rd);
      check("reg_reset", rv[i], rd);
    end
    reg_wr(5'h05, 16'h5a5a);
    reg_rd(5'h05, rd);
    check("unmapped", 16'h0000, rd);
    reg_wr(`CTSP_REG_MASK_B, 16'h1234);
    reg_rd(`CTSP_REG_MASK_B, rd);
    check("mask_b", 16'h1234, rd);
    reg_wr(`CTSP_REG_MASK_B, 16'h0000);
    reg_wr(`CTSP_REG_FIRST_CONFIG_WORD, 16'h0008);
    reg_wr(`CTSP_REG_DIG_EN, 16'h01ff);
    reg_wr(`CTSP_REG_THRESH, THR);
    sync_pulse();
    sum_chk = 1'b1;
    wait_sums(40);
    @(posedge i_link_clk);
    #1;
    check("fwd_clk", 64'(i_link_clk), 64'(o_forwarded_capture_clock));
    @(negedge i_link_clk);
    #1;
    check("fwd_clk", 64'(i_link_clk), 64'(o_forwarded_capture_clock));
    // Hit bit first masked off, capture must never finish; then unmasked, done after 512 sums
    for (int r = 0; r < 2; r++)
    begin
      wait_sums(n_sum + 1);
      reg_wr(`CTSP_REG_ARM, 16'h0001);
      reg_wr(`CTSP_REG_ARM, 16'h0000);
      base = n_sum;
      if (r == 0)
      begin
        wait_sums(base + 600);
        check("done_masked", 64'h0, 64'(o_capture_done_flag));
        reg_wr(`CTSP_REG_MASK_A, 16'h8000);
      end
      else
      begin
        wait_sums(base + 511);
        repeat (2) @(posedge i_clk);
        check("done_early", 64'h0, 64'(o_capture_done_flag));
        wait_sums(base + 512);
        repeat (5) @(posedge i_clk);
        check("done_set", 64'h1, 64'(o_capture_done_flag));
        reg_rd(`CTSP_REG_STATUS, rd);
        check("status_done", 64'h1, 64'(rd[0]));
      end
    end
    reg_wr(`CTSP_REG_ARM, 16'h0000);
    @(posedge i_clk);
    check("done_clear", 64'h0, 64'(o_capture_done_flag));
    for (int e = 0; e < 2; e++)
    begin
      reg_rd(`CTSP_REG_HIST_LO, rd);
      check("hist_lo", 16'h8000, rd);
      reg_rd(`CTSP_REG_HIST_HI, rd);
      check("hist_hi", 16'h0001, rd);
    end
    sum_chk = 1'b0;
    count_mode <= 1'b0;
    reg_wr(`CTSP_REG_FIRST_CONFIG_WORD, 16'h0009);
    wait_sums(n_sum + 20);
    repeat (20) @(posedge i_clk);
    check("mismatch_set", 64'h1, 64'(o_sum_mismatch_latch));
    sync_pulse();
    test_done();
  end
endmodule
